// File: design/atc_cfg.svh
// register offsets, field positions, reset values and event bits of the threshold block
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH
`define ATC_IDX_LOW_LO 8'hD9
`define ATC_IDX_LOW_HI 8'hDA
`define ATC_IDX_HIGH_LO 8'hDB
`define ATC_IDX_HIGH_HI 8'hDC
`define ATC_IDX_STATUS_REF 8'hDD
`define ATC_IDX_SOURCE_CAP 8'hDF
`define ATC_IDX_AUX 8'hE8
`define ATC_IDX_CTRL 8'hF0
`define ATC_IDX_RESULT_LO 8'hF1
`define ATC_IDX_RESULT_HI 8'hF2
`define ATC_IDX_IRQ_STATUS 8'hF3
`define ATC_IDX_IRQ_MASK 8'hF4
`define ATC_RST_LIMIT 8'h00
`define ATC_RST_STATUS_REF 8'h00
`define ATC_RST_SOURCE_CAP 8'h0F
`define ATC_RST_AUX 8'h00
`define ATC_RST_CTRL 8'h00
`define ATC_RST_IRQ 8'h00
`define ATC_BIT_CCM 3
`define ATC_BIT_CPOL 6
`define ATC_BIT_EXTCAP 7
`define ATC_BIT_LEGACY 3
`define ATC_AUX_WMASK 8'h88
`define ATC_SRC_WMASK 8'h7F
`define ATC_STA_WMASK 8'hFF
`define ATC_CTRL_WMASK 8'h07
`define ATC_BIT_CONV_EN 0
`define ATC_BIT_TOUCH_EN 1
`define ATC_BIT_TRIG_SEL 2
`define ATC_EV_RESULT 0
`define ATC_EV_THRESH 1
`define ATC_EV_CONV_IRQ 2
`define ATC_EV_WIDTH 3
`endif

// File: design/atc_pkg.sv
// types shared by the threshold block
package atc_pkg;
	typedef enum logic [3:0] {
		ATC_REF_VDD = 4'h0,
		ATC_REF_EXT_PIN = 4'h1,
		ATC_REF_INT_1V8 = 4'h2,
		ATC_REF_INT_2V4 = 4'h3,
		ATC_REF_INT_3V0 = 4'h4,
		ATC_REF_INT_3V6 = 4'h5
	} atc_ref_t;
	typedef enum logic [1:0] {
		ATC_SRC_PORTS = 2'h0,
		ATC_SRC_INT_1V2 = 2'h1,
		ATC_SRC_GROUND = 2'h2,
		ATC_SRC_REFERENCE = 2'h3
	} atc_src_t;
	typedef enum logic [1:0] {
		ATC_BUS_IDLE = 2'b01,
		ATC_BUS_ANSWER = 2'b10
	} atc_bus_state_t;
endpackage

// File: design/atc_window_cmp.sv
// window comparator on a conversion result against two limits
`timescale 1ns/10ps
module atc_window_cmp #(
	parameter int DATA_W = 16
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [DATA_W-1:0] sample,
	input wire logic sample_valid,
	input wire logic [DATA_W-1:0] lower_limit,
	input wire logic [DATA_W-1:0] upper_limit,
	input wire logic inside_mode,
	output logic hit,
	output logic hit_valid
);
	logic in_window;
	logic out_window;
	assign in_window = (sample >= lower_limit) && (sample <= upper_limit);
	assign out_window = (sample <= lower_limit) || (sample >= upper_limit);

	// registered so the event is one clean pulse per completed result
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			hit <= 1'b0;
			hit_valid <= 1'b0;
		end
		else
		begin
			hit_valid <= sample_valid;
			hit <= sample_valid && (inside_mode ? in_window : out_window);
		end
	end

	a_hit_outside: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		sample_valid && !inside_mode && ((sample <= lower_limit) || (sample >= upper_limit))
		|=> hit)
		else $error("outside window result not flagged");
	// both window edges count as inside
	a_hit_inside: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		sample_valid && inside_mode && (sample >= lower_limit) && (sample <= upper_limit)
		|=> hit)
		else $error("inside window result not flagged");
endmodule // atc_window_cmp

// File: design/atc_threshold_ctrl.sv
// converter threshold, source, reference and auxiliary control registers
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - reference code 01x selects external pin; 100..111 select 1.8/2.4/3.0/3.6 V.
// - polarity zero: event when result at or below lower, or at/above upper.
// - polarity one: event when result between lower and upper inclusive.
// - source 00 port masks, 01 internal 1.2 V, 10 ground, 11 reference.
// - extra capacitance field resets to all ones; code n adds 2n pF.
// - lower limit held in low and high byte registers, reset zero.
// - upper limit held likewise in two registers, reset zero.
// - with touch engine enabled the same limits feed touch thresholds.
// - auxiliary bit 7 enables touch reference external capacitor, reset zero.
// - auxiliary bit 3 selects compatible serial pin assignment.
// - status bit 3 enables continuous conversion mode.
// - trigger select one: converter interrupt from threshold, else each result.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_threshold_ctrl #(
	parameter int RESULT_W = 16
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [1:0] response,
	input wire logic [RESULT_W-1:0] conv_result,
	input wire logic conv_done,
	output logic [RESULT_W-1:0] lower_limit,
	output logic [RESULT_W-1:0] upper_limit,
	output logic touch_limits_sel,
	output logic continuous_mode,
	output logic conv_enable,
	output logic [2:0] reference_code,
	output atc_pkg::atc_ref_t reference_sel,
	output atc_pkg::atc_src_t source_sel,
	output logic [7:0] port1_channel_mask,
	output logic [7:0] port2_channel_mask,
	output logic [3:0] extra_sampling_cap,
	output logic [4:0] extra_cap_pf,
	output logic touch_reference_extcap,
	output logic legacy_pin_option,
	output logic conv_irq,
	output logic irq
);
	//////////////////////////////////////////////////////////////////////////
	// register storage
	logic [7:0] low_lo;
	logic [7:0] low_hi;
	logic [7:0] high_lo;
	logic [7:0] high_hi;
	logic [7:0] status_ref;
	logic [7:0] source_cap;
	logic [7:0] aux;
	logic [7:0] ctrl;
	logic [RESULT_W-1:0] result;
	logic [`ATC_EV_WIDTH-1:0] irq_status;
	logic [`ATC_EV_WIDTH-1:0] irq_mask;
	logic [`ATC_EV_WIDTH-1:0] events;
	logic hit;
	logic hit_valid;
	atc_pkg::atc_bus_state_t bus_state;
	logic take_write;
	logic take_read;
	logic known;

	// one byte per word, low lane only
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
		merge = (old & ~mask) | (writedata[7:0] & mask);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `ATC_IDX_LOW_LO) || (a == `ATC_IDX_LOW_HI) ||
			(a == `ATC_IDX_HIGH_LO) || (a == `ATC_IDX_HIGH_HI) ||
			(a == `ATC_IDX_STATUS_REF) || (a == `ATC_IDX_SOURCE_CAP) ||
			(a == `ATC_IDX_AUX) || (a == `ATC_IDX_CTRL) ||
			(a == `ATC_IDX_RESULT_LO) || (a == `ATC_IDX_RESULT_HI) ||
			(a == `ATC_IDX_IRQ_STATUS) || (a == `ATC_IDX_IRQ_MASK);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, answer on the second edge
	assign known = mapped(address[7:0]);
	assign waitrequest = (read || write) && (bus_state == atc_pkg::ATC_BUS_IDLE);
	assign take_write = write && (bus_state == atc_pkg::ATC_BUS_ANSWER) && byteenable[0];
	assign take_read = read && (bus_state == atc_pkg::ATC_BUS_ANSWER);
	assign response = ((read || write) && !known) ? 2'h2 : 2'h0;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			bus_state <= atc_pkg::ATC_BUS_IDLE;
		else
		begin
			unique case (bus_state)
				atc_pkg::ATC_BUS_IDLE:
					if (read || write)
						bus_state <= atc_pkg::ATC_BUS_ANSWER;
				atc_pkg::ATC_BUS_ANSWER:
					bus_state <= atc_pkg::ATC_BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			readdata <= 32'h0;
		else if ((read || write) && bus_state == atc_pkg::ATC_BUS_IDLE && read)
		begin
			unique case (address)
				`ATC_IDX_LOW_LO: readdata <= {24'h0, low_lo};
				`ATC_IDX_LOW_HI: readdata <= {24'h0, low_hi};
				`ATC_IDX_HIGH_LO: readdata <= {24'h0, high_lo};
				`ATC_IDX_HIGH_HI: readdata <= {24'h0, high_hi};
				`ATC_IDX_STATUS_REF: readdata <= {24'h0, status_ref};
				`ATC_IDX_SOURCE_CAP: readdata <= {24'h0, source_cap};
				`ATC_IDX_AUX: readdata <= {24'h0, aux};
				`ATC_IDX_CTRL: readdata <= {24'h0, ctrl};
				`ATC_IDX_RESULT_LO: readdata <= {24'h0, result[7:0]};
				`ATC_IDX_RESULT_HI: readdata <= {24'h0, result[15:8]};
				`ATC_IDX_IRQ_STATUS: readdata <= {29'h0, irq_status};
				`ATC_IDX_IRQ_MASK: readdata <= {29'h0, irq_mask};
				default: readdata <= 32'h0;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// limit registers
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			low_lo <= `ATC_RST_LIMIT;
			low_hi <= `ATC_RST_LIMIT;
			high_lo <= `ATC_RST_LIMIT;
			high_hi <= `ATC_RST_LIMIT;
		end
		else if (take_write)
		begin
			if (address == `ATC_IDX_LOW_LO)
				low_lo <= writedata[7:0];
			if (address == `ATC_IDX_LOW_HI)
				low_hi <= writedata[7:0];
			if (address == `ATC_IDX_HIGH_LO)
				high_lo <= writedata[7:0];
			if (address == `ATC_IDX_HIGH_HI)
				high_hi <= writedata[7:0];
		end
	end

	// unsigned high byte above low byte
	assign lower_limit = RESULT_W'({low_hi, low_lo});
	assign upper_limit = RESULT_W'({high_hi, high_lo});
	// same limits serve the touch engine when it is selected
	assign touch_limits_sel = ctrl[`ATC_BIT_TOUCH_EN];

	//////////////////////////////////////////////////////////////////////////
	// status/reference, source/capacitance, auxiliary, control
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			status_ref <= `ATC_RST_STATUS_REF;
			source_cap <= `ATC_RST_SOURCE_CAP;
			aux <= `ATC_RST_AUX;
			ctrl <= `ATC_RST_CTRL;
		end
		else if (take_write)
		begin
			if (address == `ATC_IDX_STATUS_REF)
				status_ref <= merge(status_ref, `ATC_STA_WMASK);
			if (address == `ATC_IDX_SOURCE_CAP)
				source_cap <= merge(source_cap, `ATC_SRC_WMASK);
			// reserved bits stay zero whatever software writes
			if (address == `ATC_IDX_AUX)
				aux <= merge(aux, `ATC_AUX_WMASK);
			if (address == `ATC_IDX_CTRL)
				ctrl <= merge(ctrl, `ATC_CTRL_WMASK);
		end
	end

	assign continuous_mode = status_ref[`ATC_BIT_CCM];
	assign conv_enable = ctrl[`ATC_BIT_CONV_EN];
	assign reference_code = status_ref[2:0];
	assign touch_reference_extcap = aux[`ATC_BIT_EXTCAP];
	assign legacy_pin_option = aux[`ATC_BIT_LEGACY];
	assign extra_sampling_cap = source_cap[3:0];
	// code n adds 2n pF; zero inhibits
	assign extra_cap_pf = {extra_sampling_cap, 1'b0};
	assign source_sel = atc_pkg::atc_src_t'(source_cap[5:4]);
	// masks only matter in port mode; forced off otherwise so no pin leaks in
	assign port1_channel_mask = (source_sel == atc_pkg::ATC_SRC_PORTS) ? 8'hFF : 8'h00;
	assign port2_channel_mask = (source_sel == atc_pkg::ATC_SRC_PORTS) ? 8'hFF : 8'h00;

	always_comb
	begin
		unique casez (reference_code)
			3'b00?: reference_sel = atc_pkg::ATC_REF_VDD;
			3'b01?: reference_sel = atc_pkg::ATC_REF_EXT_PIN;
			3'b100: reference_sel = atc_pkg::ATC_REF_INT_1V8;
			3'b101: reference_sel = atc_pkg::ATC_REF_INT_2V4;
			3'b110: reference_sel = atc_pkg::ATC_REF_INT_3V0;
			3'b111: reference_sel = atc_pkg::ATC_REF_INT_3V6;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// result capture and window compare
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			result <= '0;
		else if (conv_done)
			result <= conv_result;
	end

	atc_window_cmp #(
		.DATA_W(RESULT_W)
	) u_cmp (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.sample(conv_result),
		.sample_valid(conv_done && conv_enable),
		.lower_limit(lower_limit),
		.upper_limit(upper_limit),
		.inside_mode(source_cap[`ATC_BIT_CPOL]),
		.hit(hit),
		.hit_valid(hit_valid)
	);

	//////////////////////////////////////////////////////////////////////////
	// interrupts: sticky, write one to clear, set beats clear
	always_comb
	begin
		events = '0;
		events[`ATC_EV_RESULT] = hit_valid;
		events[`ATC_EV_THRESH] = hit;
		events[`ATC_EV_CONV_IRQ] = ctrl[`ATC_BIT_TRIG_SEL] ? hit : hit_valid;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			irq_status <= `ATC_EV_WIDTH'(`ATC_RST_IRQ);
			irq_mask <= `ATC_EV_WIDTH'(`ATC_RST_IRQ);
		end
		else
		begin
			if (take_write && address == `ATC_IDX_IRQ_STATUS)
				irq_status <= (irq_status & ~writedata[`ATC_EV_WIDTH-1:0]) | events;
			else
				irq_status <= irq_status | events;
			if (take_write && address == `ATC_IDX_IRQ_MASK)
				irq_mask <= writedata[`ATC_EV_WIDTH-1:0];
		end
	end

	assign conv_irq = irq_status[`ATC_EV_CONV_IRQ];
	assign irq = |(irq_status & irq_mask);

	//////////////////////////////////////////////////////////////////////////
	// checks: bus handshake, registers, interrupts
	// a request sees wait in its first cycle; a write lands on the answer edge
	sequence s_bus_request;
		(read || write) && waitrequest;
	endsequence
	sequence s_aux_write;
		write && !waitrequest && byteenable[0] && address == `ATC_IDX_AUX;
	endsequence

	a_trig_threshold: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		ctrl[`ATC_BIT_TRIG_SEL] && hit_valid && !hit
		&& !irq_status[`ATC_EV_CONV_IRQ] && !take_write
		|=> !irq_status[`ATC_EV_CONV_IRQ])
		else $error("result without threshold raised converter interrupt");
	a_trig_result: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!ctrl[`ATC_BIT_TRIG_SEL] && hit_valid |=> irq_status[`ATC_EV_CONV_IRQ])
		else $error("valid result did not raise converter interrupt");
	// an event in the clearing cycle must survive
	a_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
		hit_valid && take_write && address == `ATC_IDX_IRQ_STATUS
		|=> irq_status[`ATC_EV_RESULT])
		else $error("clear beat a simultaneous event");
	a_status_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
		irq_status[`ATC_EV_RESULT] && !(take_write && address == `ATC_IDX_IRQ_STATUS)
		|=> irq_status[`ATC_EV_RESULT])
		else $error("status bit dropped without a clear");

	a_ccm_bit: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		take_write && address == `ATC_IDX_STATUS_REF
		|=> continuous_mode == $past(writedata[`ATC_BIT_CCM]))
		else $error("continuous mode not taken from status bit 3");
	a_aux_reserved: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		(aux & ~`ATC_AUX_WMASK) == 8'h00)
		else $error("reserved auxiliary bits set");
	a_aux_write: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		s_aux_write |=> aux == ($past(writedata[7:0]) & `ATC_AUX_WMASK))
		else $error("auxiliary write did not land");
	a_limit_write: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		take_write && address == `ATC_IDX_LOW_LO
		|=> lower_limit[7:0] == $past(writedata[7:0]))
		else $error("lower limit byte not stored");
	a_upper_write: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		take_write && address == `ATC_IDX_HIGH_HI
		|=> upper_limit[15:8] == $past(writedata[7:0]))
		else $error("upper limit byte not stored");
	a_src_write: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		take_write && address == `ATC_IDX_SOURCE_CAP
		|=> source_sel == $past(writedata[5:4]))
		else $error("source select not stored");
	a_ref_ext: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		reference_code[2:1] == 2'b01 |-> reference_sel == atc_pkg::ATC_REF_EXT_PIN)
		else $error("external reference not selected");
	a_ref_int: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		reference_code == 3'b100 |-> reference_sel == atc_pkg::ATC_REF_INT_1V8)
		else $error("lowest internal reference not selected");
	a_cap_pf: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		extra_sampling_cap == 4'h1 |-> extra_cap_pf == 5'h02)
		else $error("capacitance code one not two picofarad");
	a_read_aux: assert property (@(posedge core_clk) disable iff (!reset_n)
		take_read && address == `ATC_IDX_AUX |-> readdata[7:0] == aux)
		else $error("read data does not stand in the answer cycle");

	a_bus_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_bus_request |=> !waitrequest)
		else $error("bus answer took more than one wait cycle");

	// reset values, seen on the edge after reset is sampled low
	a_cap_reset: assert property (
		@(posedge core_clk) !reset_n |=> extra_sampling_cap == 4'hF)
		else $error("extra capacitance not all ones after reset");
	a_limit_reset: assert property (
		@(posedge core_clk) !reset_n |=> lower_limit == '0 && upper_limit == '0)
		else $error("limits not zero after reset");
	a_aux_reset: assert property (
		@(posedge core_clk) !reset_n |=> !touch_reference_extcap)
		else $error("external capacitor enabled after reset");
endmodule // atc_threshold_ctrl

// File: tb/atc_conv_model.sv
// converter core model: answers a start with one result, repeating in continuous mode
`timescale 1ns/10ps
module atc_conv_model (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic conv_enable,
	input wire logic continuous_mode,
	input wire logic start,
	input wire logic [15:0] value,
	input wire logic [3:0] delay,
	output logic [15:0] conv_result,
	output logic conv_done
);
	logic [3:0] cnt;
	logic busy;
	logic [15:0] last;
	always_ff @(posedge core_clk)
	begin
		conv_done <= 1'b0;
		// result lines show no stale value outside the done cycle
		conv_result <= ~last;
		if (!reset_n)
		begin
			busy <= 1'b0;
			last <= 16'h0000;
		end
		else if (start && conv_enable && !busy)
		begin
			busy <= 1'b1;
			cnt <= delay;
		end
		else if (busy && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (busy)
		begin
			conv_done <= 1'b1;
			conv_result <= value;
			last <= value;
			cnt <= delay;
			busy <= continuous_mode && conv_enable;
		end
	end
endmodule // atc_conv_model

// File: tb/atc_threshold_ctrl_tb_top.sv
// self-checking bench of the threshold control block
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_threshold_ctrl_tb_top;
	logic core_clk, reset_n, read, write, waitrequest, conv_done, conv_start;
	logic touch_limits_sel, continuous_mode, conv_enable, touch_reference_extcap;
	logic legacy_pin_option, conv_irq, irq;
	logic [7:0] address, port1_channel_mask, port2_channel_mask, q;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable, extra_sampling_cap, conv_delay;
	logic [1:0] response, last_resp;
	logic [15:0] conv_result, lower_limit, upper_limit, conv_value;
	logic [2:0] reference_code;
	logic [4:0] extra_cap_pf;
	atc_pkg::atc_ref_t reference_sel;
	atc_pkg::atc_src_t source_sel;
	int err_total, compares;
	atc_pkg::atc_ref_t exp_ref [8] = '{atc_pkg::ATC_REF_VDD, atc_pkg::ATC_REF_VDD,
		atc_pkg::ATC_REF_EXT_PIN, atc_pkg::ATC_REF_EXT_PIN, atc_pkg::ATC_REF_INT_1V8,
		atc_pkg::ATC_REF_INT_2V4, atc_pkg::ATC_REF_INT_3V0, atc_pkg::ATC_REF_INT_3V6};
	logic [7:0] ra [7] = '{8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDF, 8'hE8};
	logic [7:0] re [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00};
	logic [15:0] samp [6] = '{16'h00FF, 16'h0100, 16'h0101, 16'h01FF, 16'h0200, 16'h0201};
	atc_threshold_ctrl atc_threshold_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.response(response), .conv_result(conv_result), .conv_done(conv_done),
		.lower_limit(lower_limit), .upper_limit(upper_limit),
		.touch_limits_sel(touch_limits_sel), .continuous_mode(continuous_mode),
		.conv_enable(conv_enable), .reference_code(reference_code),
		.reference_sel(reference_sel), .source_sel(source_sel),
		.port1_channel_mask(port1_channel_mask), .port2_channel_mask(port2_channel_mask),
		.extra_sampling_cap(extra_sampling_cap), .extra_cap_pf(extra_cap_pf),
		.touch_reference_extcap(touch_reference_extcap),
		.legacy_pin_option(legacy_pin_option), .conv_irq(conv_irq), .irq(irq));
	atc_conv_model atc_conv_model_i (.core_clk(core_clk), .reset_n(reset_n),
		.conv_enable(conv_enable), .continuous_mode(continuous_mode), .start(conv_start),
		.value(conv_value), .delay(conv_delay), .conv_result(conv_result),
		.conv_done(conv_done));
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask
	task automatic tmo(input int n, input int lim);
		if (n == lim)
		begin
			$display("unexpected at %0t: wait ran out", $time);
			err_total++;
			summarize();
		end
	endtask
	// holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= {24'h000000, d};
		for (n = 0; n < 16; n++)
		begin
			@(posedge core_clk);
			if (waitrequest === 1'b0)
				break;
		end
		tmo(n, 16);
		q = readdata[7:0];
		last_resp = response;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
		// the write lands on the answer edge; look only once it has settled
		@(negedge core_clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp, "register read");
	endtask
	task automatic conv(input logic [15:0] v, input logic [3:0] dl);
		int n;
		@(posedge core_clk);
		conv_value <= v;
		conv_delay <= dl;
		conv_start <= 1'b1;
		@(posedge core_clk);
		conv_start <= 1'b0;
		for (n = 0; n < 40; n++)
		begin
			@(posedge core_clk);
			if (conv_done === 1'b1)
				break;
		end
		tmo(n, 40);
		repeat (3) @(posedge core_clk);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 7; i++)
			rdchk(ra[i], re[i]);
		chk(extra_cap_pf, 32'h1E, "cap pf at reset");
	endtask
	task automatic t_ref();
		for (int c = 0; c < 8; c++)
		begin
			// continuous bit stays clear outside a continuous run
			wr(`ATC_IDX_STATUS_REF, {5'h00, c[2:0]});
			chk(reference_sel, exp_ref[c], "reference decode");
			chk(reference_code, c[2:0], "reference code");
			chk(continuous_mode, 1'b0, "continuous bit");
		end
		wr(`ATC_IDX_STATUS_REF, 8'h00);
	endtask
	task automatic t_src();
		logic [3:0] cap;
		for (int s = 0; s < 4; s++)
		begin
			cap = 4'(s * 5);
			wr(`ATC_IDX_SOURCE_CAP, {2'b10, s[1:0], cap});
			chk(source_sel, s, "source select");
			chk(port1_channel_mask, (s == 0) ? 8'hFF : 8'h00, "port gating");
			chk(port2_channel_mask, (s == 0) ? 8'hFF : 8'h00, "port gating");
			chk(extra_sampling_cap, cap, "extra cap code");
			chk(extra_cap_pf, cap * 2, "extra cap pf");
			rdchk(`ATC_IDX_SOURCE_CAP, {2'b00, s[1:0], cap});
		end
	endtask
	task automatic t_aux();
		wr(`ATC_IDX_AUX, 8'h88);
		chk({touch_reference_extcap, legacy_pin_option}, 2'b11, "aux on");
		wr(`ATC_IDX_AUX, 8'h08);
		chk({touch_reference_extcap, legacy_pin_option}, 2'b01, "aux mix");
		rdchk(`ATC_IDX_AUX, 8'h08);
		wr(8'h10, 8'h55);
		chk(last_resp, 2'h2, "unmapped write");
		rdchk(8'h10, 8'h00);
	endtask
	task automatic t_limits();
		wr(`ATC_IDX_LOW_LO, 8'h34);
		wr(`ATC_IDX_LOW_HI, 8'h12);
		wr(`ATC_IDX_HIGH_LO, 8'hCD);
		wr(`ATC_IDX_HIGH_HI, 8'hAB);
		chk({lower_limit, upper_limit}, 32'h1234ABCD, "limits");
		rdchk(`ATC_IDX_HIGH_HI, 8'hAB);
		wr(`ATC_IDX_CTRL, 8'h02);
		chk({touch_limits_sel, lower_limit}, 32'h11234, "touch limits");
		byteenable <= 4'h0;
		wr(`ATC_IDX_LOW_LO, 8'hFF);
		byteenable <= 4'hF;
		rdchk(`ATC_IDX_LOW_LO, 8'h34);
	endtask
	task automatic t_window();
		logic h;
		wr(`ATC_IDX_LOW_LO, 8'h00);
		wr(`ATC_IDX_LOW_HI, 8'h01);
		wr(`ATC_IDX_HIGH_LO, 8'h00);
		wr(`ATC_IDX_HIGH_HI, 8'h02);
		wr(`ATC_IDX_IRQ_MASK, 8'h02);
		for (int t = 0; t < 2; t++)
			for (int p = 0; p < 2; p++)
				for (int k = 0; k < 6; k++)
				begin
					// touch channel masks live outside this block and are taken as set
					wr(`ATC_IDX_CTRL, {5'h00, t[0], 2'b01});
					wr(`ATC_IDX_SOURCE_CAP, {1'b0, p[0], 6'h0F});
					wr(`ATC_IDX_IRQ_STATUS, 8'h07);
					conv(samp[k], 4'(k));
					if (p == 1)
						h = samp[k] >= 16'h0100 && samp[k] <= 16'h0200;
					else
						h = samp[k] <= 16'h0100 || samp[k] >= 16'h0200;
					rdchk(`ATC_IDX_IRQ_STATUS, {5'h00, t[0] ? h : 1'b1, h, 1'b1});
					chk(conv_irq, t[0] ? h : 1'b1, "converter irq");
					chk(irq, h, "threshold irq");
				end
		rdchk(`ATC_IDX_RESULT_LO, 8'h01);
		rdchk(`ATC_IDX_RESULT_HI, 8'h02);
		wr(`ATC_IDX_IRQ_MASK, 8'h01);
		chk(irq, 1'b1, "result irq");
		wr(`ATC_IDX_IRQ_MASK, 8'h00);
		chk(irq, 1'b0, "masked irq");
		wr(`ATC_IDX_IRQ_STATUS, 8'h01);
		wr(`ATC_IDX_IRQ_MASK, 8'h01);
		chk(irq, 1'b0, "cleared irq");
	endtask
	task automatic t_cont();
		int n;
		wr(`ATC_IDX_STATUS_REF, 8'h08);
		chk(continuous_mode, 1'b1, "continuous set");
		wr(`ATC_IDX_CTRL, 8'h01);
		chk(conv_enable, 1'b1, "converter enabled");
		conv(16'h0150, 4'h2);
		n = 0;
		repeat (20)
		begin
			@(posedge core_clk);
			n += (conv_done === 1'b1);
		end
		chk(n >= 2, 1'b1, "continuous results");
		wr(`ATC_IDX_STATUS_REF, 8'h00);
		wr(`ATC_IDX_CTRL, 8'h00);
		chk(conv_enable, 1'b0, "converter disabled");
	endtask
	initial
	begin
		reset_n = 1'b0;
		{read, write, conv_start} = 3'b000;
		address = 8'h00;
		writedata = 32'h00000000;
		byteenable = 4'hF;
		conv_value = 16'h0000;
		conv_delay = 4'h0;
		err_total = 0;
		compares = 0;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_ref();
		t_src();
		t_aux();
		t_limits();
		t_window();
		t_cont();
		summarize();
	end
endmodule // atc_threshold_ctrl_tb_top
